//--- src/pfp_defines.vh
// Constants for the program flow predictor: sizes, reset values, classes.
// Assumes inclusion by bare name from the predictor design files.
`ifndef PFP_DEFINES_VH
`define PFP_DEFINES_VH
// Structure sizes
`define PFP_BTB_IDX_W 6
`define PFP_GHR_W 8
`define PFP_RAS_DEPTH 8
`define PFP_RAS_PTR_W 3
// Reset values and counter taken bit
`define PFP_GHR_RESET 8'h00
`define PFP_CTR_RESET 2'h1
`define PFP_CTR_TAKEN_BIT 1
// Branch class codes from the decoder
`define PFP_CLS_NONE 4'h0
`define PFP_CLS_UNCOND 4'h1
`define PFP_CLS_COND 4'h2
`define PFP_CLS_CALL 4'h3
`define PFP_CLS_CALL_REG 4'h4
`define PFP_CLS_RETURN 4'h5
`define PFP_CLS_INDIRECT 4'h6
`define PFP_CLS_MODE_CHANGE 4'h7
`define PFP_CLS_EXC_RETURN 4'h8
`define PFP_CLS_FLAG_SET 4'h9
// Pop base register kinds
`define PFP_BASE_SP 2'h0
`define PFP_BASE_LR 2'h1
`define PFP_BASE_R9 2'h2
`endif

//--- src/pfp_table.v
// Small table of entries with registered read data and a clear sweep.
// Assumes a single clock; write and clear are from the predictor logic.
`timescale 1ns/1ps
module pfp_table #(
  parameter AW = 6,
  parameter DW = 32,
  parameter [DW-1:0] INIT = {DW{1'b0}}
) (
  // Clock and reset
  input wire clock_i,
  input wire reset_i,
  // Read port
  input wire [AW-1:0] rd_addr_i,
  output reg [DW-1:0] rd_data_o,
  // Write port
  input wire wr_en_i,
  input wire [AW-1:0] wr_addr_i,
  input wire [DW-1:0] wr_data_i
);
  // Storage
  reg [DW-1:0] mem [0:(1<<AW)-1];
  integer k;
  // Reset puts every entry to its known value so no software sweep is needed
  always @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      for (k = 0; k < (1<<AW); k = k + 1) begin
        mem[k] <= INIT;
      end
      rd_data_o <= INIT;
    end else begin
      if (wr_en_i) begin
        mem[wr_addr_i] <= wr_data_i;
      end
      rd_data_o <= mem[rd_addr_i];
    end
  end
endmodule

//--- src/pfp_predictor.v
// Program flow predictor at the front of the core pipeline.
// Assumes fetch gives a pre-decoded branch class one cycle per request
// and resolution reports every taken/resolved branch on the same clock.
`timescale 1ns/1ps
`include "pfp_defines.vh"
// Overview of operation
// - Prediction off: every taken branch flushes
// - Target buffer, history, indirect, stack, static
// - All branch addressing modes are predictable
// - Java exchange branch handled as register exchange
// - Flag-setting and mode-changing branches not predicted
// - If-then-else conditional branch predicted as conditional
// - Stack entry holds return address and state
// - Predicted call forms push the stack
// - Predicted link or stack returns pop
// - Handler state r9 based loads also pop
// - Exception returns never predicted
// - Indirect target from address plus history
// - Indirect target used only when taken
// - Dynamic prediction needs one prior resolution
// - Static: unconditional and calls taken, push
// - Static: backward conditional, returns taken
// - Static predictor off without address translation
// - Static never pops r9 based returns
// - Enable bit one turns prediction on
// - Reset disables, invalidates, clears history
// - Usable after reset without software
module pfp_predictor #(
  parameter AW = 32,
  parameter IW = `PFP_BTB_IDX_W,
  parameter HW = `PFP_GHR_W,
  parameter RD = `PFP_RAS_DEPTH,
  parameter RPW = `PFP_RAS_PTR_W
) (
  // Clock and reset
  input wire clock_i,
  input wire reset_i,
  // System control levels
  input wire flow_predict_enable_i,
  input wire translation_enable_i,
  // Fetch side request, pre-decoded
  input wire fetch_valid_i,
  input wire [AW-1:0] fetch_pc_i,
  input wire fetch_state_i,
  input wire [3:0] fetch_class_i,
  input wire fetch_handler_state_i,
  input wire [1:0] fetch_base_i,
  input wire fetch_cond_i,
  input wire [AW-1:0] fetch_imm_target_i,
  input wire [AW-1:0] fetch_link_i,
  // Prediction answer to fetch
  output reg pred_valid_o,
  output reg pred_taken_o,
  output reg [AW-1:0] pred_target_o,
  output reg pred_target_state_o,
  // Resolution side
  input wire resolve_valid_i,
  input wire [AW-1:0] resolve_pc_i,
  input wire [3:0] resolve_class_i,
  input wire resolve_taken_i,
  input wire [AW-1:0] resolve_target_i,
  input wire resolve_pred_taken_i,
  input wire [AW-1:0] resolve_pred_target_i,
  // Flush and redirect to fetch
  output reg flush_o,
  output reg [AW-1:0] redirect_pc_o
);
  // Target buffer entry: valid, tag, target
  localparam TW = AW - IW - 1;
  localparam BW = 1 + TW + AW;
  // Indirect entries (valid + target); direction counter entries are 2 bits
  localparam XW = 1 + AW;

  // Classification of the fetched branch
  reg is_push;
  reg is_pop;
  reg never_pred;
  reg [IW-1:0] f_idx;
  reg [IW-1:0] f_hidx;

  // Held copies of the request, aligned with registered table reads
  reg s1_valid;
  reg [AW-1:0] s1_pc;
  reg [3:0] s1_class;
  reg s1_push;
  reg s1_pop;
  reg s1_never;
  reg s1_cond;
  reg s1_r9pop;
  reg [AW-1:0] s1_imm;

  // Global history register
  reg [HW-1:0] ghr;

  // Return stack storage and pointers
  reg [AW:0] ras_mem [0:RD-1];
  reg [RPW-1:0] ras_top;
  reg [RPW:0] ras_count;
  integer i;

  // Table read data
  wire [BW-1:0] btb_rd;
  wire [1:0] ctr_rd;
  wire [XW-1:0] ind_rd;

  // Table write controls
  wire [IW-1:0] r_idx;
  wire [IW-1:0] r_hidx;
  reg [1:0] next_ctr;
  wire mispredict;

  // Resolution held one cycle, until its counter read has returned
  reg upd_valid;
  reg upd_taken;
  reg [IW-1:0] upd_hidx;

  // Decode the class at fetch time
  always @* begin
    is_push = 1'b0;
    is_pop = 1'b0;
    never_pred = 1'b0;
    case (fetch_class_i)
      // Immediate and register calls both push
      `PFP_CLS_CALL: is_push = 1'b1;
      `PFP_CLS_CALL_REG: is_push = 1'b1;
      // Both exchange branch forms arrive here as a register target
      `PFP_CLS_INDIRECT: never_pred = 1'b0;
      // Link, sp, or handler-state r9 based returns pop
      `PFP_CLS_RETURN: begin
        is_pop = (fetch_base_i != `PFP_BASE_R9) ||
                 fetch_handler_state_i;
      end
      // These can change privilege, so they are left to resolution
      `PFP_CLS_MODE_CHANGE: never_pred = 1'b1;
      `PFP_CLS_EXC_RETURN: never_pred = 1'b1;
      `PFP_CLS_FLAG_SET: never_pred = 1'b1;
      default: never_pred = 1'b0;
    endcase
  end

  // Index hashes: plain for target buffer, pc xor history otherwise
  always @* begin
    f_idx = fetch_pc_i[IW:1];
    f_hidx = fetch_pc_i[IW:1] ^ ghr[IW-1:0];
  end

  assign r_idx = resolve_pc_i[IW:1];
  assign r_hidx = resolve_pc_i[IW:1] ^ ghr[IW-1:0];

  // Wrong direction, or wrong target on a taken branch
  assign mispredict = resolve_valid_i &&
    ((resolve_taken_i != resolve_pred_taken_i) ||
     (resolve_taken_i && resolve_target_i != resolve_pred_target_i));

  // Stage the resolution; index keeps the history of its own cycle
  always @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      upd_valid <= 1'b0;
      upd_taken <= 1'b0;
      upd_hidx <= {IW{1'b0}};
    end else begin
      upd_valid <= resolve_valid_i;
      upd_taken <= resolve_taken_i;
      upd_hidx <= r_hidx;
    end
  end

  // Saturating counter update toward the resolved direction
  always @* begin
    next_ctr = ctr_rd;
    if (upd_taken && ctr_rd != 2'h3) begin
      next_ctr = ctr_rd + 2'h1;
    end else if (!upd_taken && ctr_rd != 2'h0) begin
      next_ctr = ctr_rd - 2'h1;
    end
  end

  // Target buffer: only written on resolution, so never hits cold
  pfp_table #(.AW(IW), .DW(BW), .INIT({BW{1'b0}})) u_btb (
    .clock_i(clock_i),
    .reset_i(reset_i),
    .rd_addr_i(f_idx),
    .rd_data_o(btb_rd),
    .wr_en_i(resolve_valid_i && resolve_taken_i),
    .wr_addr_i(r_idx),
    .wr_data_i({1'b1, resolve_pc_i[AW-1:IW+1], resolve_target_i})
  );

  // Direction counters of the second history level
  // Resolution borrows the single read port, then writes one cycle later;
  // a fetch in the borrowed cycle sees the resolved entry's counter.
  pfp_table #(.AW(IW), .DW(2), .INIT(`PFP_CTR_RESET)) u_pht (
    .clock_i(clock_i),
    .reset_i(reset_i),
    .rd_addr_i(resolve_valid_i ? r_hidx : f_hidx),
    .rd_data_o(ctr_rd),
    .wr_en_i(upd_valid),
    .wr_addr_i(upd_hidx),
    .wr_data_i(next_ctr)
  );

  // Indirect target predictor indexed by address and history
  pfp_table #(.AW(IW), .DW(XW), .INIT({XW{1'b0}})) u_ind (
    .clock_i(clock_i),
    .reset_i(reset_i),
    .rd_addr_i(f_hidx),
    .rd_data_o(ind_rd),
    .wr_en_i(resolve_valid_i && resolve_taken_i &&
             (resolve_class_i == `PFP_CLS_INDIRECT ||
              resolve_class_i == `PFP_CLS_CALL_REG)),
    .wr_addr_i(r_hidx),
    .wr_data_i({1'b1, resolve_target_i})
  );

  // Stage the fetch request alongside registered reads
  always @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      s1_valid <= 1'b0;
      s1_pc <= {AW{1'b0}};
      s1_class <= `PFP_CLS_NONE;
      s1_push <= 1'b0;
      s1_pop <= 1'b0;
      s1_never <= 1'b0;
      s1_cond <= 1'b0;
      s1_r9pop <= 1'b0;
      s1_imm <= {AW{1'b0}};
    end else begin
      s1_valid <= fetch_valid_i;
      s1_pc <= fetch_pc_i;
      s1_class <= fetch_class_i;
      s1_push <= fetch_valid_i && is_push && !never_pred;
      s1_pop <= fetch_valid_i && is_pop && !never_pred;
      s1_never <= never_pred;
      // Conditional execution inside an if-then block counts as cond
      s1_cond <= fetch_cond_i;
      s1_r9pop <= (fetch_base_i == `PFP_BASE_R9);
      s1_imm <= fetch_imm_target_i;
    end
  end

  // Prediction decision, combined from all five structures
  reg dyn_hit;
  reg d_taken;
  reg [AW-1:0] d_target;
  reg d_valid;
  reg d_pop;
  reg ras_ok;
  reg stat_on;
  always @* begin
    dyn_hit = btb_rd[BW-1] &&
      btb_rd[AW+TW-1:AW] == s1_pc[AW-1:IW+1];
    ras_ok = (ras_count != {(RPW+1){1'b0}});
    stat_on = translation_enable_i;
    d_valid = 1'b0;
    d_taken = 1'b0;
    d_target = {AW{1'b0}};
    d_pop = 1'b0;
    if (s1_valid && flow_predict_enable_i && !s1_never) begin
      if (s1_pop && ras_ok) begin
        // Return: target from the stack top
        d_valid = dyn_hit || (stat_on && !s1_r9pop);
        d_taken = d_valid && !s1_cond;
        d_target = ras_mem[ras_top][AW:1];
        d_pop = d_valid;
      end else if (s1_class == `PFP_CLS_INDIRECT ||
                   s1_class == `PFP_CLS_CALL_REG) begin
        // Direction from counters, target only when taken
        d_valid = dyn_hit && ind_rd[XW-1];
        d_taken = d_valid && (!s1_cond ||
                  ctr_rd[`PFP_CTR_TAKEN_BIT]);
        d_target = ind_rd[AW-1:0];
      end else if (dyn_hit) begin
        // Dynamic prediction of a previously resolved branch
        d_valid = 1'b1;
        d_taken = !s1_cond || ctr_rd[`PFP_CTR_TAKEN_BIT];
        d_target = btb_rd[AW-1:0];
      end else if (stat_on) begin
        // Cold code static rules
        case (s1_class)
          // Made conditional by an if-then block: backward only
          `PFP_CLS_UNCOND: d_valid = !s1_cond || s1_imm < s1_pc;
          `PFP_CLS_CALL: d_valid = !s1_cond || s1_imm < s1_pc;
          `PFP_CLS_COND: d_valid = s1_imm < s1_pc;
          default: d_valid = 1'b0;
        endcase
        d_taken = d_valid;
        d_target = s1_imm;
      end
    end
  end

  // Prediction outputs; link state travels in bit 0 of stack entries
  always @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      pred_valid_o <= 1'b0;
      pred_taken_o <= 1'b0;
      pred_target_o <= {AW{1'b0}};
      pred_target_state_o <= 1'b0;
    end else begin
      pred_valid_o <= d_valid;
      pred_taken_o <= d_taken;
      pred_target_o <= d_target;
      pred_target_state_o <= d_pop ? ras_mem[ras_top][0] : 1'b0;
    end
  end

  // Return stack: circular, oldest overwritten on overflow
  always @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      ras_top <= {RPW{1'b0}};
      ras_count <= {(RPW+1){1'b0}};
      for (i = 0; i < RD; i = i + 1) begin
        ras_mem[i] <= {(AW+1){1'b0}};
      end
    end else if (mispredict) begin
      // Speculative entries are unreliable after a redirect
      ras_count <= {(RPW+1){1'b0}};
    end else if (d_taken && s1_push) begin
      // Store address after the call, same as the link value, and state
      ras_mem[ras_top + 1'b1] <= {fetch_link_i, fetch_state_i};
      ras_top <= ras_top + 1'b1;
      if (ras_count != RD[RPW:0]) begin
        ras_count <= ras_count + 1'b1;
      end
    end else if (d_pop && d_taken) begin
      ras_top <= ras_top - 1'b1;
      ras_count <= ras_count - 1'b1;
    end
  end

  // Global history shifts in every resolved conditional outcome
  always @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      ghr <= `PFP_GHR_RESET;
    end else if (resolve_valid_i && resolve_class_i == `PFP_CLS_COND) begin
      ghr <= {ghr[HW-2:0], resolve_taken_i};
    end
  end

  // Flush on mispredict; with prediction off every taken branch flushes
  always @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      flush_o <= 1'b0;
      redirect_pc_o <= {AW{1'b0}};
    end else begin
      flush_o <= mispredict ||
        (resolve_valid_i && resolve_taken_i &&
         !flow_predict_enable_i);
      redirect_pc_o <= resolve_target_i;
    end
  end
endmodule

//--- bench/pfp_monitor.sv
// Checker for the flow predictor, watching its top-level ports only.
// Assumes one clock domain and the class codes of the defines header.
`timescale 1ns/1ps
`include "pfp_defines.vh"
module pfp_monitor #(
  parameter AW = 32
) (
  // Clock and reset
  input wire clock_i,
  input wire reset_i,
  // Inputs watched
  input wire flow_predict_enable_i,
  input wire fetch_valid_i,
  input wire [3:0] fetch_class_i,
  input wire resolve_valid_i,
  input wire resolve_taken_i,
  input wire [AW-1:0] resolve_target_i,
  input wire resolve_pred_taken_i,
  // Outputs watched
  input wire pred_valid_o,
  input wire pred_taken_o,
  input wire flush_o,
  input wire [AW-1:0] redirect_pc_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (reset_i);
  // Quiet in reset and on the first edge after it, so no reset guard
  AST_RESET_QUIET: assert property (disable iff (1'b0)
    (reset_i || $past(reset_i)) |-> !pred_valid_o && !flush_o)
    else $error("output active around reset");
  // Refused classes never give a prediction
  AST_REFUSED: assert property (
    fetch_valid_i && (fetch_class_i inside {`PFP_CLS_MODE_CHANGE,
    `PFP_CLS_EXC_RETURN, `PFP_CLS_FLAG_SET}) |-> ##2 !pred_valid_o)
    else $error("refused class was predicted");
  // Enable held low over the whole lookup means nothing is taken
  AST_DISABLED: assert property (
    fetch_valid_i && !flow_predict_enable_i ##1 !flow_predict_enable_i
    ##1 !flow_predict_enable_i |-> !pred_taken_o)
    else $error("prediction while disabled");
  // A prediction always comes from a fetch two edges back
  AST_PRED_CAUSE: assert property (
    pred_valid_o |-> $past(fetch_valid_i, 2))
    else $error("prediction without fetch");
  // Taken is only ever given with a valid prediction
  AST_TAKEN_VALID: assert property (
    pred_taken_o |-> pred_valid_o)
    else $error("taken without valid");
  // With prediction off every taken branch flushes to its target
  AST_FLUSH_OFF: assert property (
    resolve_valid_i && resolve_taken_i && !flow_predict_enable_i |=>
    flush_o && redirect_pc_o == $past(resolve_target_i))
    else $error("taken branch not flushed while off");
  // Wrong direction flushes on the next edge
  AST_MISPREDICT: assert property (
    resolve_valid_i && flow_predict_enable_i &&
    (resolve_taken_i != resolve_pred_taken_i) |=> flush_o)
    else $error("mispredict not flushed");
  // Missed taken branch redirects to the resolved target
  AST_REDIRECT: assert property (
    resolve_valid_i && resolve_taken_i && !resolve_pred_taken_i |=>
    redirect_pc_o == $past(resolve_target_i))
    else $error("wrong redirect target");
  // A flush only follows a resolution
  AST_FLUSH_CAUSE: assert property (
    flush_o |-> $past(resolve_valid_i))
    else $error("flush without resolve");
endmodule
bind pfp_predictor pfp_monitor #(.AW(AW)) mon_u (.*);

//--- bench/pfp_far_end.sv
// Far-end model: fetch stage and branch resolution around the predictor.
// Assumes the bench calls its tasks; all fields move on clock_i.
`timescale 1ns/1ps
module pfp_far_end (
  // Clock
  input wire clock_i,
  // Fetch request, named as the predictor's inputs
  output reg fetch_valid_i,
  output reg [31:0] fetch_pc_i,
  output reg fetch_state_i,
  output reg [3:0] fetch_class_i,
  output reg fetch_handler_state_i,
  output reg [1:0] fetch_base_i,
  output reg fetch_cond_i,
  output reg [31:0] fetch_imm_target_i,
  output reg [31:0] fetch_link_i,
  // Resolution report
  output reg resolve_valid_i,
  output reg [31:0] resolve_pc_i,
  output reg [3:0] resolve_class_i,
  output reg resolve_taken_i,
  output reg [31:0] resolve_target_i,
  output reg resolve_pred_taken_i,
  output reg [31:0] resolve_pred_target_i,
  // Answers
  input wire pred_valid_o,
  input wire pred_taken_o,
  input wire [31:0] pred_target_o,
  input wire pred_target_state_o,
  input wire flush_o,
  input wire [31:0] redirect_pc_o
);
  // Idle values at time zero
  initial begin
    fetch_valid_i = 1'b0;
    resolve_valid_i = 1'b0;
    {fetch_pc_i, fetch_state_i, fetch_class_i, fetch_handler_state_i} = '0;
    {fetch_base_i, fetch_cond_i, fetch_imm_target_i, fetch_link_i} = '0;
    {resolve_pc_i, resolve_class_i, resolve_taken_i, resolve_target_i} = '0;
    {resolve_pred_taken_i, resolve_pred_target_i} = '0;
  end
  // One fetch; answer stands in the cycle after the capture edge + 1
  task fetch(input [3:0] c, input [31:0] pc, input [31:0] im,
             input [1:0] b, input cd, input h, input [31:0] lk,
             input st, output v, output t, output [31:0] tg, output s);
    @(posedge clock_i);
    fetch_valid_i <= 1'b1;
    fetch_class_i <= c;
    fetch_pc_i <= pc;
    fetch_imm_target_i <= im;
    fetch_base_i <= b;
    fetch_cond_i <= cd;
    fetch_handler_state_i <= h;
    fetch_link_i <= lk;
    fetch_state_i <= st;
    @(posedge clock_i);
    // Link and state stay for the push; released fields are inverted
    fetch_valid_i <= 1'b0;
    fetch_pc_i <= ~pc;
    fetch_imm_target_i <= ~im;
    @(posedge clock_i);
    #1;
    v = pred_valid_o;
    t = pred_taken_o;
    tg = pred_target_o;
    s = pred_target_state_o;
  endtask
  // One resolution after lag idle cycles; flush stands after capture
  task resolve(input [3:0] c, input [31:0] pc, input tk,
               input [31:0] tg, input pt, input [31:0] ptg,
               input integer lag, output fl, output [31:0] rd);
    repeat (lag) @(posedge clock_i);
    @(posedge clock_i);
    resolve_valid_i <= 1'b1;
    resolve_class_i <= c;
    resolve_pc_i <= pc;
    resolve_taken_i <= tk;
    resolve_target_i <= tg;
    resolve_pred_taken_i <= pt;
    resolve_pred_target_i <= ptg;
    @(posedge clock_i);
    resolve_valid_i <= 1'b0;
    resolve_pc_i <= ~pc;
    resolve_target_i <= ~tg;
    resolve_pred_target_i <= ~ptg;
    #1;
    fl = flush_o;
    rd = redirect_pc_o;
  endtask
endmodule

//--- bench/tb_top.sv
// Self-checking bench for the flow predictor with its far-end model.
// Assumes default design sizes; the checker is bound separately.
`timescale 1ns/1ps
`include "pfp_defines.vh"
module tb_top;
  // Clock, reset and system levels
  reg clock_i = 1'b0;
  reg reset_i = 1'b0;
  reg flow_predict_enable_i = 1'b0;
  reg translation_enable_i = 1'b0;
  // Model-driven fields
  wire fetch_valid_i, fetch_state_i, fetch_handler_state_i, fetch_cond_i;
  wire [31:0] fetch_pc_i, fetch_imm_target_i, fetch_link_i;
  wire [3:0] fetch_class_i, resolve_class_i;
  wire [1:0] fetch_base_i;
  wire resolve_valid_i, resolve_taken_i, resolve_pred_taken_i;
  wire [31:0] resolve_pc_i, resolve_target_i, resolve_pred_target_i;
  // Predictor answers
  wire pred_valid_o, pred_taken_o, pred_target_state_o, flush_o;
  wire [31:0] pred_target_o, redirect_pc_o;
  // Results and bookkeeping
  reg v, t, s, fl;
  reg [31:0] tg, rd;
  integer failures = 0, samples_checked = 0, cycles = 0, i;
  reg [70:0] rows [0:6]; // class, cond, pc, target, 0 refused/1 no/2 taken
  pfp_predictor dut_u (.*);
  pfp_far_end far_u (.*);
  always #2.5 clock_i = ~clock_i;
  task chk32(input [31:0] g, input [31:0] e);
    samples_checked = samples_checked + 1;
    if (g !== e) begin
      failures = failures + 1;
      $display("Error at %0t: got %h exp %h", $time, g, e);
    end
  endtask
  task chk1(input g, input e);
    chk32({31'h0, g}, {31'h0, e});
  endtask
  // Fetch with link set to the next instruction, state one
  task ft(input [3:0] c, input [31:0] pc, input [31:0] im,
          input [1:0] b, input h);
    far_u.fetch(c, pc, im, b, 1'b0, h, pc + 32'h0000_0004, 1'b1,
      v, t, tg, s);
  endtask
  task rs(input [31:0] pc, input tk, input [31:0] tg, input pt,
          input integer lag);
    far_u.resolve(`PFP_CLS_UNCOND, pc, tk, tg, pt, pt ? tg : 32'h0, lag,
      fl, rd);
  endtask
  task done(input [8*8-1:0] name);
    $display("test %0s finished", name);
  endtask
  task wrap_up;
    $display("compares %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // Hang guard; the whole run needs under two hundred cycles
  always @(posedge clock_i) begin
    cycles = cycles + 1;
    if (cycles == 3000) begin
      failures = failures + 1;
      wrap_up;
    end
  end
  initial begin
    // Rising edge at time zero so the asynchronous reset really acts
    reset_i <= 1'b1;
    rows[0] = {`PFP_CLS_UNCOND, 1'b0, 32'h0000_0100, 32'h0000_0200, 2'd2};
    rows[1] = {`PFP_CLS_COND, 1'b1, 32'h0000_0300, 32'h0000_0280, 2'd2};
    rows[2] = {`PFP_CLS_COND, 1'b1, 32'h0000_0400, 32'h0000_0480, 2'd1};
    rows[3] = {`PFP_CLS_MODE_CHANGE, 1'b0, 32'h0000_0500, 32'h0, 2'd0};
    rows[4] = {`PFP_CLS_EXC_RETURN, 1'b0, 32'h0000_0600, 32'h0, 2'd0};
    rows[5] = {`PFP_CLS_FLAG_SET, 1'b0, 32'h0000_0680, 32'h0, 2'd0};
    rows[6] = {`PFP_CLS_UNCOND, 1'b1, 32'h0000_0780, 32'h0000_0740, 2'd2};
    repeat (12) @(posedge clock_i);
    reset_i <= 1'b0;
    @(posedge clock_i);
    #1;
    chk1(pred_valid_o, 1'b0);
    chk1(flush_o, 1'b0);
    done("reset");
    // Translation on but prediction off: static path must stay quiet
    @(posedge clock_i);
    translation_enable_i <= 1'b1;
    ft(`PFP_CLS_UNCOND, 32'h0000_0080, 32'h0000_00c0, 2'h0, 1'b0);
    chk1(t, 1'b0);
    rs(32'h0000_0040, 1'b1, 32'h0000_00a0, 1'b0, 3);
    chk1(fl, 1'b1);
    chk32(rd, 32'h0000_00a0);
    done("off");
    @(posedge clock_i);
    flow_predict_enable_i <= 1'b1;
    for (i = 0; i < 7; i = i + 1) begin
      far_u.fetch(rows[i][70:67], rows[i][65:34], rows[i][33:2], 2'h0,
        rows[i][66], 1'b0, 32'h0, 1'b0, v, t, tg, s);
      if (rows[i][1:0] == 2'd0)
        chk1(v, 1'b0);
      else
        chk1(t, rows[i][1]);
      if (rows[i][1])
        chk32(tg, rows[i][33:2]);
    end
    done("static");
    // Push, pop, then pop from an empty stack
    ft(`PFP_CLS_CALL, 32'h0000_0800, 32'h0000_0900, 2'h0, 1'b0);
    chk32(tg, 32'h0000_0900);
    ft(`PFP_CLS_RETURN, 32'h0000_0904, 32'h0, 2'h0, 1'b0);
    chk32(tg, 32'h0000_0804);
    chk1(s, 1'b1);
    ft(`PFP_CLS_RETURN, 32'h0000_0908, 32'h0, 2'h0, 1'b0);
    chk1(t, 1'b0);
    // Base r9 pop is not static-predicted and leaves the entry
    ft(`PFP_CLS_CALL, 32'h0000_0a00, 32'h0000_0b00, 2'h0, 1'b0);
    ft(`PFP_CLS_RETURN, 32'h0000_0b04, 32'h0, 2'h2, 1'b1);
    chk1(t, 1'b0);
    ft(`PFP_CLS_RETURN, 32'h0000_0b08, 32'h0, 2'h0, 1'b0);
    chk32(tg, 32'h0000_0a04);
    // Nine pushes overwrite the oldest; eight pops come back newest first
    for (i = 0; i < 9; i = i + 1)
      ft(`PFP_CLS_CALL, 32'h0000_2000 + (i << 4), 32'h0000_3000, 2'h0, 1'b0);
    for (i = 8; i > 0; i = i - 1) begin
      ft(`PFP_CLS_RETURN, 32'h0000_4000 + (i << 4), 32'h0, 2'h0, 1'b0);
      chk32(tg, 32'h0000_2004 + (i << 4));
    end
    done("stack");
    // Static off; dynamic path learns from one resolution
    @(posedge clock_i);
    translation_enable_i <= 1'b0;
    ft(`PFP_CLS_UNCOND, 32'h0000_0700, 32'h0000_0900, 2'h0, 1'b0);
    chk1(t, 1'b0);
    rs(32'h0000_0700, 1'b1, 32'h0000_0900, 1'b0, 0);
    chk1(fl, 1'b1);
    chk32(rd, 32'h0000_0900);
    ft(`PFP_CLS_UNCOND, 32'h0000_0700, 32'h0000_0900, 2'h0, 1'b0);
    chk1(t, 1'b1);
    chk32(tg, 32'h0000_0900);
    rs(32'h0000_0700, 1'b1, 32'h0000_0900, 1'b1, 3);
    chk1(fl, 1'b0);
    done("dynamic");
    // Indirect target learned once, then direction from the counter
    far_u.resolve(`PFP_CLS_INDIRECT, 32'h0000_0c10, 1'b1, 32'h0000_0d00,
      1'b0, 32'h0, 0, fl, rd);
    chk1(fl, 1'b1);
    ft(`PFP_CLS_INDIRECT, 32'h0000_0c10, 32'h0, 2'h0, 1'b0);
    chk1(t, 1'b1);
    chk32(tg, 32'h0000_0d00);
    far_u.resolve(`PFP_CLS_INDIRECT, 32'h0000_0c10, 1'b0, 32'h0000_0c14,
      1'b1, 32'h0000_0d00, 0, fl, rd);
    chk1(fl, 1'b1);
    chk32(rd, 32'h0000_0c14);
    far_u.fetch(`PFP_CLS_INDIRECT, 32'h0000_0c10, 32'h0, 2'h0, 1'b1, 1'b0,
      32'h0, 1'b0, v, t, tg, s);
    chk1(v, 1'b1);
    chk1(t, 1'b0);
    // Register call learned once pushes; a static return pops it
    far_u.resolve(`PFP_CLS_CALL_REG, 32'h0000_0c20, 1'b1, 32'h0000_0e00,
      1'b0, 32'h0, 0, fl, rd);
    ft(`PFP_CLS_CALL_REG, 32'h0000_0c20, 32'h0, 2'h0, 1'b0);
    chk32(tg, 32'h0000_0e00);
    @(posedge clock_i);
    translation_enable_i <= 1'b1;
    ft(`PFP_CLS_RETURN, 32'h0000_0e10, 32'h0, 2'h0, 1'b0);
    chk32(tg, 32'h0000_0c24);
    done("indirect");
    wrap_up;
  end
endmodule
